/* dcc_pkg.sv */
// Purpose: constants and carriers for the dac clear control block
// Assumes: 16-bit registers on a plain strobe port, 10 MHz clock
// Notes:   per-dac fields sit in bits 14..3 of each control register
package dcc_pkg;

    localparam int unsigned NUM_DACS       = 12;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned FIELD_LSB      = 3;
    localparam int unsigned FIELD_MSB      = 14;

    localparam logic [ADDR_W-1:0] SW_CLEAR_OFFSET   = 8'h55;
    localparam logic [ADDR_W-1:0] PIN0_ENABLE_OFFSET = 8'h56;
    localparam logic [ADDR_W-1:0] CLEAR_STATUS_OFFSET = 8'h5F;

    localparam logic [DATA_W-1:0]   SW_CLEAR_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0]   PIN0_ENABLE_RESET = 16'h0000;
    localparam logic [NUM_DACS-1:0] DAC_MASK_RESET    = 12'h000;

    // one register access from the master
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } dcc_bus_req_type;

endpackage : dcc_pkg

/* dcc_pin_sync.sv */
// Purpose: two-stage synchroniser for the external active-low clear pin
// Assumes: pin is asynchronous to clk
// Notes:   first stage feeds only the second stage
module dcc_pin_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin_n,
    output logic      pin_sync_n
);
    import dcc_pkg::*;

    typedef struct packed {
        logic meta_n;
        logic sync_n;
    } dcc_sync_state_type;

    dcc_sync_state_type st_q;
    dcc_sync_state_type st_d;

    ////////////////////////////////////////////////////////////////////////////////
    // shift the pin in; resets to released (high) so no clear fires after reset
    always_comb begin
        st_d        = st_q;
        st_d.meta_n = pin_n;
        st_d.sync_n = st_q.meta_n;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '{meta_n: 1'b1, sync_n: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_sync_n = st_q.sync_n;

endmodule : dcc_pin_sync

/* dcc_clear_ctrl.sv */
// Purpose: software and pin-driven clear control for twelve dacs
// Assumes: clear_pin_0_n is asynchronous; register port on clk
// Notes:   reads return data in the cycle after the strobe
//
// Contract
// - software field bits 14..3 force clear
// - writing zero releases software clear
// - pin0 enable field bits 14..3 selects dacs
// - enabled dac clears while pin low
// - disabled dac ignores the pin
// - pin0 enable register resets to zero
//
// The plain strobed port was decided locally.
module dcc_clear_ctrl (
    input  wire logic                           clk,
    input  wire logic                           srst,
    input  wire logic [dcc_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [dcc_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [dcc_pkg::DATA_W-1:0]     reg_rdata,
    input  wire logic                           clear_pin_0_n,
    output logic      [dcc_pkg::NUM_DACS-1:0]   dac_clear
);
    import dcc_pkg::*;

    typedef struct packed {
        logic [NUM_DACS-1:0] sw_clear_bits;
        logic [NUM_DACS-1:0] pin0_clear_enable_bits;
        logic [NUM_DACS-1:0] clear;
        logic [DATA_W-1:0]   rdata;
    } dcc_state_type;

    dcc_state_type   st_q;
    dcc_state_type   st_d;
    dcc_bus_req_type req;
    logic            pin0_sync_n;
    logic [NUM_DACS-1:0] clear_next;

    ////////////////////////////////////////////////////////////////////////////////
    // pin passes two flops before any logic looks at it
    dcc_pin_sync u_pin0_sync (
        .clk        (clk),
        .srst       (srst),
        .pin_n      (clear_pin_0_n),
        .pin_sync_n (pin0_sync_n)
    );

    // bundle the bus inputs
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    ////////////////////////////////////////////////////////////////////////////////
    // per-dac clear request; one loop so every channel is built the same
    for (genvar i = 0; i < NUM_DACS; i++) begin : g_dac
        // software force, or pin low with this dac enabled
        assign clear_next[i] = st_q.sw_clear_bits[i]
                             | (~pin0_sync_n & st_q.pin0_clear_enable_bits[i]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register writes, read mux and the registered clear outputs
    always_comb begin
        st_d       = st_q;
        st_d.clear = clear_next;
        st_d.rdata = '0;
        if (req.wr) begin
            if (req.addr == SW_CLEAR_OFFSET) begin
                // ones force, zeros release
                st_d.sw_clear_bits = req.wdata[FIELD_MSB:FIELD_LSB];
            end else if (req.addr == PIN0_ENABLE_OFFSET) begin
                st_d.pin0_clear_enable_bits = req.wdata[FIELD_MSB:FIELD_LSB];
            end
        end
        // unmapped and reserved bits read zero
        if (req.rd) begin
            if (req.addr == SW_CLEAR_OFFSET) begin
                st_d.rdata[FIELD_MSB:FIELD_LSB] = st_q.sw_clear_bits;
            end else if (req.addr == PIN0_ENABLE_OFFSET) begin
                st_d.rdata[FIELD_MSB:FIELD_LSB] = st_q.pin0_clear_enable_bits;
            end else if (req.addr == CLEAR_STATUS_OFFSET) begin
                st_d.rdata[FIELD_MSB:FIELD_LSB] = st_q.clear;  // live clear state
            end
        end
    end

    // register everything; enables reset to zero so the pin is ignored at start
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q.sw_clear_bits          <= SW_CLEAR_RESET[FIELD_MSB:FIELD_LSB];
            st_q.pin0_clear_enable_bits <= PIN0_ENABLE_RESET[FIELD_MSB:FIELD_LSB];
            st_q.clear                  <= DAC_MASK_RESET;
            st_q.rdata                  <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign dac_clear = st_q.clear;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_sw_force;
        @(posedge clk) disable iff (srst)
        (reg_wr && reg_addr == SW_CLEAR_OFFSET && reg_wdata[FIELD_LSB]) |=> ##1 dac_clear[0];
    endproperty
    a_sw_force : assert property (p_sw_force) else $error("software clear did not force dac0");

    // a release write for dac0, then a quiet cycle with its pin path disabled
    sequence s_sw_release_write;
        (reg_wr && reg_addr == SW_CLEAR_OFFSET && !reg_wdata[FIELD_LSB])
            ##1 (!reg_wr && st_q.pin0_clear_enable_bits[0] == 1'b0);
    endsequence

    property p_sw_release;
        @(posedge clk) disable iff (srst)
        s_sw_release_write |=> !dac_clear[0];
    endproperty
    a_sw_release : assert property (p_sw_release) else $error("software release did not free dac0");

    property p_en_write;
        @(posedge clk) disable iff (srst)
        (reg_wr && reg_addr == PIN0_ENABLE_OFFSET)
            |=> st_q.pin0_clear_enable_bits == $past(reg_wdata[FIELD_MSB:FIELD_LSB]);
    endproperty
    a_en_write : assert property (p_en_write) else $error("pin0 enable field not stored");

    sequence s_pin_low_enabled;
        !clear_pin_0_n ##1 !clear_pin_0_n ##1 (!clear_pin_0_n && st_q.pin0_clear_enable_bits[5]);
    endsequence

    property p_pin_clear;
        @(posedge clk) disable iff (srst)
        s_pin_low_enabled |=> dac_clear[5];
    endproperty
    a_pin_clear : assert property (p_pin_clear) else $error("pin low did not clear enabled dac5");

    property p_pin_ignored;
        @(posedge clk) disable iff (srst)
        (!st_q.pin0_clear_enable_bits[5] && !st_q.sw_clear_bits[5]) |=> !dac_clear[5];
    endproperty
    a_pin_ignored : assert property (p_pin_ignored) else $error("disabled dac5 was cleared");

    property p_reset_en;
        @(posedge clk)
        srst |=> (st_q.pin0_clear_enable_bits == '0 && dac_clear == '0);
    endproperty
    a_reset_en : assert property (p_reset_en) else $error("enable register not zero after reset");

    property p_or_sources;
        @(posedge clk) disable iff (srst)
        1'b1 |=> dac_clear == ($past(st_q.sw_clear_bits)
                               | ($past(pin0_sync_n) ? '0 : $past(st_q.pin0_clear_enable_bits)));
    endproperty
    a_or_sources : assert property (p_or_sources) else $error("clear is not the or of sources");

    property p_read_timing;
        @(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == PIN0_ENABLE_OFFSET && !reg_wr)
            |=> reg_rdata == {1'b0, $past(st_q.pin0_clear_enable_bits), 3'b000};
    endproperty
    a_read_timing : assert property (p_read_timing) else $error("enable read data wrong");

    ////////////////////////////////////////////////////////////////////////////////
    // read path: data stands one cycle after the strobe, zero everywhere else
    property p_sw_read;
        @(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == SW_CLEAR_OFFSET)
            |=> reg_rdata == {1'b0, $past(st_q.sw_clear_bits), 3'b000};
    endproperty
    a_sw_read : assert property (p_sw_read) else $error("software field read data wrong");

    // status shows the registered clear lines as the dacs see them
    property p_status_read;
        @(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == CLEAR_STATUS_OFFSET)
            |=> reg_rdata == {1'b0, $past(dac_clear), 3'b000};
    endproperty
    a_status_read : assert property (p_status_read) else $error("clear status read data wrong");

    // software must learn nothing from a hole in the map
    property p_unmapped_read;
        @(posedge clk) disable iff (srst)
        (reg_rd && reg_addr != SW_CLEAR_OFFSET && reg_addr != PIN0_ENABLE_OFFSET
            && reg_addr != CLEAR_STATUS_OFFSET) |=> reg_rdata == '0;
    endproperty
    a_unmapped_read : assert property (p_unmapped_read) else $error("unmapped read returned data");

    // one-cycle answer, so a late sampler sees zero rather than stale data
    property p_rdata_idle;
        @(posedge clk) disable iff (srst)
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata_idle : assert property (p_rdata_idle) else $error("read data stood without a read");

    ////////////////////////////////////////////////////////////////////////////////
    // register storage: a field moves only on a write to its own offset
    property p_sw_write;
        @(posedge clk) disable iff (srst)
        (reg_wr && reg_addr == SW_CLEAR_OFFSET)
            |=> st_q.sw_clear_bits == $past(reg_wdata[FIELD_MSB:FIELD_LSB]);
    endproperty
    a_sw_write : assert property (p_sw_write) else $error("software field not stored");

    // the status offset is read-only; a write there leaves both fields alone
    property p_status_write_ignored;
        @(posedge clk) disable iff (srst)
        (reg_wr && reg_addr == CLEAR_STATUS_OFFSET)
            |=> ($stable(st_q.sw_clear_bits) && $stable(st_q.pin0_clear_enable_bits));
    endproperty
    a_status_write_ignored : assert property (p_status_write_ignored) else $error("status write changed a field");

    // no write to the software offset means the software field holds
    property p_sw_hold;
        @(posedge clk) disable iff (srst)
        !(reg_wr && reg_addr == SW_CLEAR_OFFSET) |=> $stable(st_q.sw_clear_bits);
    endproperty
    a_sw_hold : assert property (p_sw_hold) else $error("software field moved without a write");

    // same for the pin enable field
    property p_en_hold;
        @(posedge clk) disable iff (srst)
        !(reg_wr && reg_addr == PIN0_ENABLE_OFFSET) |=> $stable(st_q.pin0_clear_enable_bits);
    endproperty
    a_en_hold : assert property (p_en_hold) else $error("enable field moved without a write");

    // the software field also leaves reset released, so no dac starts cleared
    property p_sw_reset;
        @(posedge clk)
        srst |=> (st_q.sw_clear_bits == '0 && reg_rdata == '0);
    endproperty
    a_sw_reset : assert property (p_sw_reset) else $error("software field not zero after reset");

    ////////////////////////////////////////////////////////////////////////////////
    // pin path: two synchroniser stages, then the registered clear
    // a low level on the pin reaches the synchronised copy two edges later
    property p_sync_low;
        @(posedge clk) disable iff (srst)
        !clear_pin_0_n |=> ##1 !pin0_sync_n;
    endproperty
    a_sync_low : assert property (p_sync_low) else $error("pin low not seen after two stages");

    // a released pin goes through with the same latency
    property p_sync_high;
        @(posedge clk) disable iff (srst)
        clear_pin_0_n |=> ##1 pin0_sync_n;
    endproperty
    a_sync_high : assert property (p_sync_high) else $error("pin release not seen after two stages");

    // once a release has passed the flops, software alone decides
    sequence s_pin_released;
        clear_pin_0_n ##1 clear_pin_0_n ##1 (clear_pin_0_n && st_q.sw_clear_bits == '0);
    endsequence

    property p_pin_release;
        @(posedge clk) disable iff (srst)
        s_pin_released |=> dac_clear == '0;
    endproperty
    a_pin_release : assert property (p_pin_release) else $error("clear stayed after pin release");

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel checks; one loop so no dac goes unwatched, not just dac0 and dac5
    for (genvar c = 0; c < NUM_DACS; c++) begin : g_chk
        // a software write that sets this dac's bit
        sequence s_ch_sw_set;
            reg_wr && reg_addr == SW_CLEAR_OFFSET && reg_wdata[FIELD_LSB + c];
        endsequence

        property p_ch_sw_force;
            @(posedge clk) disable iff (srst)
            s_ch_sw_set |=> ##1 dac_clear[c];
        endproperty
        a_ch_sw_force : assert property (p_ch_sw_force) else $error("software set did not clear its dac");

        // a software write that drops this dac's bit, with its pin path off
        sequence s_ch_sw_drop;
            (reg_wr && reg_addr == SW_CLEAR_OFFSET && !reg_wdata[FIELD_LSB + c])
                ##1 (!reg_wr && (pin0_sync_n || !st_q.pin0_clear_enable_bits[c]));
        endsequence

        property p_ch_sw_release;
            @(posedge clk) disable iff (srst)
            s_ch_sw_drop |=> !dac_clear[c];
        endproperty
        a_ch_sw_release : assert property (p_ch_sw_release) else $error("software release left its dac cleared");

        // synchronised pin low with the enable set clears the dac on the next edge
        property p_ch_pin_force;
            @(posedge clk) disable iff (srst)
            (!pin0_sync_n && st_q.pin0_clear_enable_bits[c]) |=> dac_clear[c];
        endproperty
        a_ch_pin_force : assert property (p_ch_pin_force) else $error("enabled dac ignored the pin");

        // the same pin level leaves a disabled dac alone
        property p_ch_pin_ignored;
            @(posedge clk) disable iff (srst)
            (!pin0_sync_n && !st_q.pin0_clear_enable_bits[c] && !st_q.sw_clear_bits[c]) |=> !dac_clear[c];
        endproperty
        a_ch_pin_ignored : assert property (p_ch_pin_ignored) else $error("disabled dac followed the pin");

        // a set software bit clears the dac whatever the pin does
        property p_ch_sw_hold;
            @(posedge clk) disable iff (srst)
            st_q.sw_clear_bits[c] |=> dac_clear[c];
        endproperty
        a_ch_sw_hold : assert property (p_ch_sw_hold) else $error("software bit set but dac not cleared");
    end

endmodule : dcc_clear_ctrl

/* dcc_pin_model.sv */
// Purpose: external logic that drives the active-low clear pin
// Assumes: the bench asks for the pin through hold_low
// Notes:   pin idles released (high), as a pulled-up line would
module dcc_pin_model (
    input  wire logic clk,
    input  wire logic hold_low,
    output logic      clear_pin_0_n
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////
    // released at time zero so the device never sees a stray clear;
    // one process drives the pin, and it moves only after an edge
    initial begin
        clear_pin_0_n = 1'b1;
        forever begin
            @(posedge clk);
            clear_pin_0_n <= !hold_low;
        end
    end
endmodule : dcc_pin_model

/* dcc_clear_ctrl_tb.sv */
// Purpose: self-checking bench for the dac clear control block
// Assumes: 10 MHz clock, reads answer one cycle after the strobe
// Notes:   pin path is given six cycles to cover the synchroniser
module dcc_clear_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dcc_pkg::*;
    logic                clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pin_hold = 1'b0;
    logic [ADDR_W-1:0]   reg_addr = 8'h00;
    logic [DATA_W-1:0]   reg_wdata = 16'h0000, reg_rdata, sw_w, en_w;
    logic [NUM_DACS-1:0] dac_clear;
    logic                clear_pin_0_n, low;
    int                  n_errors = 0, check_count = 0, cycles = 0;
    dcc_clear_ctrl dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clear_pin_0_n(clear_pin_0_n), .dac_clear(dac_clear));
    dcc_pin_model far_end (.clk(clk), .hold_low(pin_hold), .clear_pin_0_n(clear_pin_0_n));
    ////////////////////////////////////////////////////////////////
    // clock and a hang guard well above the expected run length
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    ////////////////////////////////////////////////////////////////
    // bus cycles: one strobe cycle, read data taken in the next one
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    // reserved bits 15 and 2..0 never read back
    function automatic logic [15:0] field_of(input logic [15:0] d);
        return d & 16'h7FF8;
    endfunction : field_of
    function automatic logic [15:0] exp_clear(input logic [15:0] sw, input logic [15:0] en, input logic lo);
        return {4'h0, sw[14:3] | (lo ? en[14:3] : 12'h000)};
    endfunction : exp_clear
    ////////////////////////////////////////////////////////////////
    // reset, register checks, then random mixes of all clear sources
    initial begin
        logic [15:0] rd;
        void'($urandom(32'h57d1c1bb));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        reg_read(PIN0_ENABLE_OFFSET, rd);
        check("enable reset", rd, PIN0_ENABLE_RESET);
        check("clear after reset", {4'h0, dac_clear}, 16'h0000);
        reg_read(8'h10, rd);
        check("unmapped read", rd, 16'h0000);
        for (int i = 0; i < 30; i++) begin
            sw_w = $urandom(); en_w = $urandom(); low = 1'($urandom());
            // corner: every dac enabled, then none, with the pin low
            if (i < 2) begin
                sw_w = 16'h0000; en_w = (i == 0) ? 16'hFFFF : 16'h0000; low = 1'b1;
            end
            reg_write(SW_CLEAR_OFFSET, sw_w);
            reg_write(PIN0_ENABLE_OFFSET, en_w);
            pin_hold <= low;
            // the status offset is read-only: this write must reach neither field
            reg_write(CLEAR_STATUS_OFFSET, ~sw_w);
            reg_read(SW_CLEAR_OFFSET, rd);
            check("software field", rd, field_of(sw_w));
            reg_read(PIN0_ENABLE_OFFSET, rd);
            check("enable field", rd, field_of(en_w));
            repeat (6) @(posedge clk);
            #1 check("clear mix", {4'h0, dac_clear}, exp_clear(sw_w, en_w, low));
            reg_read(CLEAR_STATUS_OFFSET, rd);
            check("clear status", rd, exp_clear(sw_w, en_w, low) << 3);
            reg_write(SW_CLEAR_OFFSET, 16'h0000);
            repeat (2) @(posedge clk);
            #1 check("software release", {4'h0, dac_clear}, exp_clear(16'h0000, en_w, low));
            pin_hold <= 1'b0;
            repeat (6) @(posedge clk);
            #1 check("pin release", {4'h0, dac_clear}, 16'h0000);
        end
        // second reset in mid-run, with every source armed and the pin held low
        reg_write(SW_CLEAR_OFFSET, 16'hFFFF);
        reg_write(PIN0_ENABLE_OFFSET, 16'hFFFF);
        pin_hold <= 1'b1;
        srst     <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check("clear after mid reset", {4'h0, dac_clear}, 16'h0000);
        reg_read(PIN0_ENABLE_OFFSET, rd);
        check("enable after mid reset", rd, PIN0_ENABLE_RESET);
        reg_read(SW_CLEAR_OFFSET, rd);
        check("software after mid reset", rd, SW_CLEAR_RESET);
        stop_test();
    end
endmodule : dcc_clear_ctrl_tb
